/* File: rtl/pin_ovr_regs.svh */
// Purpose: Offsets, field positions, reset values and fixed pin positions for the pin override block
// Assumes: 32-bit register words on byte addresses, 8-bit address space
// Notes:   Pin vector index is port*8 + bit, ports A..D as 0..3
`ifndef PIN_OVR_REGS_SVH
`define PIN_OVR_REGS_SVH

`define AXIL_AW          8
`define OFF_DIR          8'h00
`define OFF_AFEN         8'h04
`define OFF_ALT_SELECT_FIRST         8'h08
`define OFF_ALT_SELECT_SECOND         8'h0C
`define OFF_LED_SINK_ENABLE        8'h10
`define OFF_LEDHI        8'h14
`define OFF_LEDLO        8'h18
`define OFF_CTRL         8'h1C
`define OFF_STATUS       8'h20
`define OFF_IMPL         8'h24

`define RST_DIR          32'hFFFFFFFF
`define CTRL_RELEASE_BIT 0
`define STAT_DEBUG_BIT   0
`define STAT_XTAL_BIT    1
`define STAT_RELEASE_BIT 2

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define PIN_A0           0
`define PIN_A1           1
`define PIN_A2           2
`define PIN_A6           6
`define PIN_C_BASE       16
`define PIN_D0           24

`endif

/* File: rtl/pin_ovr_pkg.sv */
// Purpose: Types shared by the pin override block and its bench
// Assumes: Constants come from pin_ovr_regs.svh
// Notes:   Pin owner codes are one-hot
`include "pin_ovr_regs.svh"

package pin_ovr_pkg;

  typedef enum logic [1:0] {
    PKG_SMALL = 2'h0,
    PKG_MID   = 2'h1,
    PKG_LARGE = 2'h2
  } package_e;

  typedef enum logic [5:0] {
    OWN_NONE  = 6'h01,
    OWN_DEBUG = 6'h02,
    OWN_XTAL  = 6'h04,
    OWN_RESET = 6'h08,
    OWN_ALT   = 6'h10,
    OWN_GPIO  = 6'h20
  } owner_e;

  typedef struct packed {
    logic                   awvalid;
    logic [`AXIL_AW-1:0]    awaddr;
    logic                   wvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`AXIL_AW-1:0]    araddr;
    logic                   rready;
  } axil_req_s;

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic [31:0]            dir;
    logic [31:0]            af_en;
    logic [31:0]            alt_select_first;
    logic [31:0]            alt_select_second;
    logic [7:0]             led_en;
    logic [7:0]             led_hi;
    logic [7:0]             led_lo;
    logic                   release_pin;
    logic                   debug_on;
    logic                   reset_seq_d;
    logic [31:0]            sync1;
    logic [31:0]            sync2;
    logic [31:0]            pin_out;
    logic [31:0]            pin_oe;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } pin_state_s;

endpackage

/* File: rtl/pin_override_ctrl.sv */
// Purpose: Per-pin owner selection (GPIO, alternate function, crystal, reset, debug) and LED sink control
// Assumes: Data registers, peripherals, oscillator and debugger sit outside and run on sys_clk
// Notes:   Pin outputs are registered, one cycle behind their causes
// Notes on behaviour
// - Alternate enable picks GPIO or alternate use
// - Alternate mode takes direction from the peripheral
// - Set registers choose among several alternate functions; here only the first set register acts, picking func0 or func1
// - Crystal enable takes over port A pins 0,1; in the small package pin 0 stays with debug while debug is on
// - Timer mode picks input or complement output
// - Two level registers give four sink levels
// - LED sink only where enable bit set
// - Shared port D pin starts as reset pin
// - Port D pin in GPIO: open-drain output only
// - No pull-up, high drive, recovery on pin
// - Small package: reset on port A pin 2
// - System reset returns pin to reset role
// - Small package debug pin starts as input
// - Debug pin watched during each reset sequence
// - Unlock enables debug, removes pin from GPIO
// - No unlock keeps debug off until next reset
// - Small package: port A bits 5..0 only
// - Mid package: A 7..0, B/C 3..0, D0
// - Large package: A,C 7..0, B by converter, D0
// - Port A has no set registers
// - Port B selection uses first set register only
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`include "pin_ovr_regs.svh"

module pin_override_ctrl #(
  parameter pin_ovr_pkg::package_e PKG     = pin_ovr_pkg::PKG_LARGE,
  parameter bit                    HAS_ADC = 1'b1
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // Register bus
  input  wire pin_ovr_pkg::axil_req_s axil_req,
  output var  pin_ovr_pkg::axil_rsp_s axil_rsp,
  // Port data registers
  input  wire logic [31:0]           gpio_out,
  // Peripheral functions
  input  wire logic [31:0]           func0_out,
  input  wire logic [31:0]           func0_oe,
  input  wire logic [31:0]           func1_out,
  input  wire logic [31:0]           func1_oe,
  input  wire logic [1:0]            timer_out_mode,
  input  wire logic [1:0]            timer_comp_out,
  // Oscillator, reset and debug
  input  wire logic                  xtal_enable,
  input  wire logic                  reset_seq,
  input  wire logic                  chip_reset_drive,
  input  wire logic                  unlock_seen,
  input  wire logic                  dbg_out,
  input  wire logic                  dbg_oe,
  output var  logic                  debug_enable,
  output var  logic                  ext_reset_req,
  // Pads
  input  wire logic [31:0]           pin_in,
  output var  logic [31:0]           pin_out,
  output var  logic [31:0]           pin_oe,
  output var  logic [31:0]           pin_in_sync,
  output var  logic [31:0]           pad_feature_allow,
  // LED drive on port C
  output var  logic [7:0]            led_sink_en,
  output var  logic [15:0]           led_level
);

  localparam bit IS_SMALL = (PKG == pin_ovr_pkg::PKG_SMALL);
  localparam logic [7:0] IMPL_A = IS_SMALL ? 8'h3F : 8'hFF;
  localparam logic [7:0] IMPL_B = IS_SMALL ? 8'h00 : (PKG == pin_ovr_pkg::PKG_MID) ? 8'h0F :
                                  HAS_ADC ? 8'h3F : 8'hFF;
  localparam logic [7:0] IMPL_C = IS_SMALL ? 8'h00 : (PKG == pin_ovr_pkg::PKG_MID) ? 8'h0F : 8'hFF;
  localparam logic [7:0] IMPL_D = IS_SMALL ? 8'h00 : 8'h01;
  localparam logic [31:0] IMPL  = {IMPL_D, IMPL_C, IMPL_B, IMPL_A};
  localparam logic [31:0] SET_MASK = {8'h00, IMPL_C, IMPL_B, 8'h00};
  localparam int RST_PIN = IS_SMALL ? `PIN_A2 : `PIN_D0;

  pin_ovr_pkg::pin_state_s s;
  pin_ovr_pkg::pin_state_s s_next;
  logic [31:0]             mux_out;
  logic [31:0]             mux_oe;
  logic                    wr_take;
  logic                    rd_take;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b+:8] = d[8*b+:8];
      end
    end
    return r;
  endfunction

  // Per-pin owner and drive
  for (genvar i = 0; i < 32; i++) begin : g_pin
    localparam bit TWO_FUNC = (i >= 8) && (i < 24);
    localparam bit TIMER    = (i == `PIN_A0) || (i == `PIN_A6);
    localparam int TIDX     = (i == `PIN_A6) ? 1 : 0;
    pin_ovr_pkg::owner_e owner;
    logic                alt_o;
    logic                alt_e;

    always_comb begin
      alt_o = (TWO_FUNC && s.alt_select_first[i]) ? func1_out[i] : func0_out[i];
      alt_e = (TWO_FUNC && s.alt_select_first[i]) ? func1_oe[i] : func0_oe[i];
      if (TIMER) begin
        alt_e = timer_out_mode[TIDX];
        alt_o = timer_comp_out[TIDX];
      end
      if (!IMPL[i]) begin
        owner = pin_ovr_pkg::OWN_NONE;
      end else if (IS_SMALL && i == `PIN_A0 && s.debug_on) begin
        owner = pin_ovr_pkg::OWN_DEBUG;
      end else if ((i == `PIN_A0 || i == `PIN_A1) && xtal_enable) begin
        owner = pin_ovr_pkg::OWN_XTAL;
      end else if (i == RST_PIN && !s.release_pin) begin
        owner = pin_ovr_pkg::OWN_RESET;
      end else if (s.af_en[i]) begin
        owner = pin_ovr_pkg::OWN_ALT;
      end else begin
        owner = pin_ovr_pkg::OWN_GPIO;
      end
      case (owner)
        pin_ovr_pkg::OWN_DEBUG: begin
          mux_out[i] = dbg_out;
          mux_oe[i]  = dbg_oe;
        end
        pin_ovr_pkg::OWN_RESET: begin
          mux_out[i] = 1'b0;
          mux_oe[i]  = chip_reset_drive;
        end
        pin_ovr_pkg::OWN_ALT: begin
          mux_out[i] = alt_o;
          mux_oe[i]  = alt_e;
        end
        pin_ovr_pkg::OWN_GPIO: begin
          if (!IS_SMALL && i == `PIN_D0) begin
            mux_out[i] = 1'b0;
            mux_oe[i]  = !s.dir[i] && !gpio_out[i];
          end else begin
            mux_out[i] = gpio_out[i];
            mux_oe[i]  = !s.dir[i];
          end
        end
        default: begin
          mux_out[i] = 1'b0;
          mux_oe[i]  = 1'b0;
        end
      endcase
    end

    if (i >= `PIN_C_BASE && i < `PIN_C_BASE + 8) begin : g_led
      assign led_sink_en[i-`PIN_C_BASE] = s.led_en[i-`PIN_C_BASE] && IMPL[i];
      assign led_level[2*(i-`PIN_C_BASE)+:2] = {s.led_hi[i-`PIN_C_BASE], s.led_lo[i-`PIN_C_BASE]};
    end
  end

  assign wr_take = axil_req.awvalid && axil_req.wvalid && !s.bvalid;
  assign rd_take = axil_req.arvalid && !s.rvalid;

  always_comb begin
    s_next             = s;
    s_next.sync1       = pin_in;
    s_next.sync2       = s.sync1;
    s_next.reset_seq_d = reset_seq;
    s_next.pin_out     = mux_out;
    s_next.pin_oe      = mux_oe;

    // Register writes
    if (s.bvalid && axil_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_take) begin
      s_next.bvalid = 1'b1;
      s_next.bresp  = `RESP_OKAY;
      if (axil_req.awaddr == `OFF_DIR) begin
        s_next.dir = merge(s.dir, axil_req.wdata, axil_req.wstrb) | ~IMPL;
      end else if (axil_req.awaddr == `OFF_AFEN) begin
        s_next.af_en = merge(s.af_en, axil_req.wdata, axil_req.wstrb) & IMPL;
      end else if (axil_req.awaddr == `OFF_ALT_SELECT_FIRST) begin
        s_next.alt_select_first = merge(s.alt_select_first, axil_req.wdata, axil_req.wstrb) & SET_MASK;
      end else if (axil_req.awaddr == `OFF_ALT_SELECT_SECOND) begin
        s_next.alt_select_second = merge(s.alt_select_second, axil_req.wdata, axil_req.wstrb) & SET_MASK;
      end else if (axil_req.awaddr == `OFF_LED_SINK_ENABLE) begin
        if (axil_req.wstrb[0]) s_next.led_en = axil_req.wdata[7:0] & IMPL_C;
      end else if (axil_req.awaddr == `OFF_LEDHI) begin
        if (axil_req.wstrb[0]) s_next.led_hi = axil_req.wdata[7:0] & IMPL_C;
      end else if (axil_req.awaddr == `OFF_LEDLO) begin
        if (axil_req.wstrb[0]) s_next.led_lo = axil_req.wdata[7:0] & IMPL_C;
      end else if (axil_req.awaddr == `OFF_CTRL) begin
        if (axil_req.wstrb[0]) s_next.release_pin = axil_req.wdata[`CTRL_RELEASE_BIT];
      end else begin
        s_next.bresp = `RESP_SLVERR;
      end
    end

    // Register reads
    if (s.rvalid && axil_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_take) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `RESP_OKAY;
      s_next.rdata  = 32'h00000000;
      if (axil_req.araddr == `OFF_DIR) begin
        s_next.rdata = s.dir & IMPL;
      end else if (axil_req.araddr == `OFF_AFEN) begin
        s_next.rdata = s.af_en;
      end else if (axil_req.araddr == `OFF_ALT_SELECT_FIRST) begin
        s_next.rdata = s.alt_select_first;
      end else if (axil_req.araddr == `OFF_ALT_SELECT_SECOND) begin
        s_next.rdata = s.alt_select_second;
      end else if (axil_req.araddr == `OFF_LED_SINK_ENABLE) begin
        s_next.rdata[7:0] = s.led_en;
      end else if (axil_req.araddr == `OFF_LEDHI) begin
        s_next.rdata[7:0] = s.led_hi;
      end else if (axil_req.araddr == `OFF_LEDLO) begin
        s_next.rdata[7:0] = s.led_lo;
      end else if (axil_req.araddr == `OFF_CTRL) begin
        s_next.rdata[`CTRL_RELEASE_BIT] = s.release_pin;
      end else if (axil_req.araddr == `OFF_STATUS) begin
        s_next.rdata[`STAT_DEBUG_BIT]   = s.debug_on;
        s_next.rdata[`STAT_XTAL_BIT]    = xtal_enable;
        s_next.rdata[`STAT_RELEASE_BIT] = s.release_pin;
      end else if (axil_req.araddr == `OFF_IMPL) begin
        s_next.rdata = IMPL;
      end else begin
        s_next.rresp = `RESP_SLVERR;
      end
    end

    // A system reset beats a same-cycle release write
    if (reset_seq) begin
      s_next.release_pin = 1'b0;
    end

    // Debug unlock: cleared at reset entry, set if the sequence shows up inside the window
    if (IS_SMALL) begin
      if (reset_seq && !s.reset_seq_d) begin
        s_next.debug_on = 1'b0;
      end
      if (reset_seq && unlock_seen) begin
        s_next.debug_on = 1'b1;
      end
    end else begin
      s_next.debug_on = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s       <= '0;
      s.dir   <= `RST_DIR;
      // Synchronisers start at the pull-up level so no false reset request follows rstn
      s.sync1 <= 32'hFFFFFFFF;
      s.sync2 <= 32'hFFFFFFFF;
    end else begin
      s <= s_next;
    end
  end

  assign axil_rsp.awready = wr_take;
  assign axil_rsp.wready  = wr_take;
  assign axil_rsp.bvalid  = s.bvalid;
  assign axil_rsp.bresp   = s.bresp;
  assign axil_rsp.arready = !s.rvalid;
  assign axil_rsp.rvalid  = s.rvalid;
  assign axil_rsp.rdata   = s.rdata;
  assign axil_rsp.rresp   = s.rresp;

  assign pin_out       = s.pin_out;
  assign pin_oe        = s.pin_oe;
  assign debug_enable  = s.debug_on;
  assign ext_reset_req = !s.release_pin && !s.sync2[RST_PIN];

  // Pad input is blocked where the pin cannot act as an input
  always_comb begin
    pin_in_sync = s.sync2 & IMPL;
    if (!IS_SMALL && s.release_pin) begin
      pin_in_sync[`PIN_D0] = 1'b0;
    end
    pad_feature_allow          = IMPL;
    pad_feature_allow[`PIN_D0] = 1'b0;
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence unlock_s;
    IS_SMALL && reset_seq && unlock_seen;
  endsequence
  sequence debug_drive_s;
    debug_enable ##1 (pin_oe[`PIN_A0] == $past(dbg_oe) && pin_out[`PIN_A0] == $past(dbg_out));
  endsequence
  sequence led_sink_enable_wr_s;
    wr_take && axil_req.awaddr == `OFF_LED_SINK_ENABLE && axil_req.wstrb[0];
  endsequence

  gpio_dir_a: assert property (!s.af_en[3] |=> pin_oe[3] == !$past(s.dir[3]))
    else $error("pin direction does not follow direction register");
  alt_dir_a: assert property (s.af_en[3] |=> pin_oe[3] == $past(func0_oe[3]))
    else $error("alternate pin direction not from peripheral");
  alt_sel_a: assert property (IMPL[8] && s.af_en[8] && s.alt_select_first[8] |=> pin_oe[8] == $past(func1_oe[8]))
    else $error("second alternate function not selected");
  porta_set_a: assert property (s.alt_select_first[7:0] == 8'h00 && s.alt_select_second[7:0] == 8'h00)
    else $error("port A set register bits are not zero");
  xtal_over_a: assert property (xtal_enable && !s.debug_on |=> !pin_oe[`PIN_A0] && !pin_oe[`PIN_A1])
    else $error("crystal pins still driven");
  timer_pin_a: assert property (IMPL[6] && s.af_en[6] && timer_out_mode[1]
                                |=> pin_oe[6] && pin_out[6] == $past(timer_comp_out[1]))
    else $error("timer complement output not on pin");
  led_wr_a: assert property (led_sink_enable_wr_s |=> ##1 led_sink_en == ($past(axil_req.wdata[7:0], 2) & IMPL_C))
    else $error("LED sink enable not taken from write");
  unlock_a: assert property (unlock_s |=> debug_drive_s)
    else $error("debug not enabled after unlock");
  locked_a: assert property (IS_SMALL && reset_seq && !s.reset_seq_d && !unlock_seen |=> !debug_enable)
    else $error("debug on without unlock");
  rst_return_a: assert property (reset_seq |=> !s.release_pin ##1 (pin_out[RST_PIN] == 1'b0))
    else $error("reset pin not returned");
  rst_hold_a: assert property (!s.release_pin && !(IS_SMALL && xtal_enable)
                               |=> pin_oe[RST_PIN] == $past(chip_reset_drive))
    else $error("reset pin not driven as reset output");
  pd0_od_a: assert property (!IS_SMALL && s.release_pin && !s.af_en[`PIN_D0]
                             |=> !pin_out[`PIN_D0] && pin_oe[`PIN_D0] == (!$past(s.dir[`PIN_D0])
                                 && !$past(gpio_out[`PIN_D0])))
    else $error("shared pin not open drain in GPIO mode");
  impl_a: assert property ((pin_oe & ~IMPL) == 32'h00000000 && !pad_feature_allow[`PIN_D0])
    else $error("absent pin driven or feature allowed");

endmodule // pin_override_ctrl

/* File: dv/pin_partner.sv */
// Purpose: Board pads and debugger on the far side of the pin override block
// Assumes: Every pad has a weak pull-up; ext_low pulls a pad low from the board
// Notes:   The debugger shows its unlock pattern only inside a reset window
`include "pin_ovr_regs.svh"

module pin_partner (
  // Pads
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_low,
  output var  logic [31:0] pin_in,
  // Debugger
  input  wire logic        reset_seq,
  input  wire logic        dbg_want,
  output var  logic        unlock_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] board_low;

  // Board lets go of port A pin 2, the small package reset pad, while the chip is in reset
  assign board_low = ext_low & ~({31'h0, reset_seq} << `PIN_A2);
  // A pad nobody drives sits at the pull-up level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~board_low);
  assign unlock_seen = dbg_want & reset_seq;
endmodule // pin_partner

/* File: dv/pin_override_ctrl_bench.sv */
// Purpose: Self-checking bench for the pin override block, large package with converter
// Assumes: Bus slave answers one cycle after taking a request; pins lag their causes by one edge
// Notes:   Debug sharing of the small package is not exercised here
`include "pin_ovr_regs.svh"

module pin_override_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] IMPL_MASK = 32'h01FF3FFF;
  localparam logic [31:0] OUT_MASK  = 32'h00FF3FFF;
  localparam logic [31:0] AF_EN     = 32'h00FF3F3C;
  localparam logic [31:0] AF_SEL    = 32'h00FF3000;
  localparam logic [31:0] GPIO_PAT  = 32'hA5C35A96;

  logic                   sys_clk;
  logic                   rstn;
  pin_ovr_pkg::axil_req_s axil_req;
  pin_ovr_pkg::axil_rsp_s axil_rsp;
  logic [31:0]            gpio_out, func0_out, func0_oe, func1_out, func1_oe;
  logic [1:0]             timer_out_mode, timer_comp_out;
  logic                   xtal_enable, reset_seq, chip_reset_drive, unlock_seen, dbg_out, dbg_oe;
  logic                   debug_enable, ext_reset_req, dbg_want;
  logic [31:0]            pin_in, pin_out, pin_oe, pin_in_sync, pad_feature_allow, ext_low;
  logic [7:0]             led_sink_en;
  logic [15:0]            led_level;
  int                     n_fail, n_checks;

  pin_override_ctrl #(.PKG(pin_ovr_pkg::PKG_LARGE), .HAS_ADC(1'b1)) pin_override_ctrl_i (
    .sys_clk, .rstn, .axil_req, .axil_rsp, .gpio_out, .func0_out, .func0_oe, .func1_out, .func1_oe,
    .timer_out_mode, .timer_comp_out, .xtal_enable, .reset_seq, .chip_reset_drive, .unlock_seen,
    .dbg_out, .dbg_oe, .debug_enable, .ext_reset_req, .pin_in, .pin_out, .pin_oe, .pin_in_sync,
    .pad_feature_allow, .led_sink_en, .led_level
  );
  pin_partner pin_partner_i (.pin_out, .pin_oe, .ext_low, .pin_in, .reset_seq, .dbg_want, .unlock_seen);

  always #10 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    axil_req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1, default: '0};
    do @(posedge sys_clk); while (axil_rsp.awready !== 1'b1);
    axil_req.awvalid <= 1'b0;
    axil_req.wvalid <= 1'b0;
    do @(posedge sys_clk); while (axil_rsp.bvalid !== 1'b1);
    check(32'(axil_rsp.bresp), 32'(er));
    axil_req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    axil_req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do @(posedge sys_clk); while (axil_rsp.arready !== 1'b1);
    axil_req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (axil_rsp.rvalid !== 1'b1);
    check(axil_rsp.rdata, ed);
    check(32'(axil_rsp.rresp), 32'(er));
    axil_req.rready <= 1'b0;
  endtask

  // Lets input changes pass the pad synchronisers and the output stage
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic t_reset();
    @(negedge sys_clk);
    check(pin_oe, 32'h0);
    check(32'(pad_feature_allow[`PIN_D0]), 32'h0);
    rd(`OFF_IMPL, IMPL_MASK, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h0, `RESP_OKAY);
    @(posedge sys_clk);
    ext_low <= 32'h01000000;
    chip_reset_drive <= 1'b1;
    settle();
    check(32'(ext_reset_req), 32'h1);
    check(32'({pin_oe[`PIN_D0], pin_out[`PIN_D0]}), 32'h2);
    @(posedge sys_clk);
    ext_low <= 32'h0;
    chip_reset_drive <= 1'b0;
  endtask

  task automatic t_gpio();
    @(posedge sys_clk);
    gpio_out <= GPIO_PAT;
    wr(`OFF_DIR, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`OFF_DIR, IMPL_MASK, `RESP_OKAY);
    wr(`OFF_DIR, 32'h0, `RESP_OKAY);
    settle();
    check(pin_oe, OUT_MASK);
    check(pin_out, GPIO_PAT & OUT_MASK);
  endtask

  task automatic t_alt();
    logic [31:0] eoe, eout;
    @(posedge sys_clk);
    func0_out <= 32'h33333333;
    func0_oe <= 32'h55555555;
    func1_out <= 32'hCCCCCCCC;
    func1_oe <= 32'hAAAAAAAA;
    wr(`OFF_ALT_SELECT_FIRST, 32'hFFFFF0F0, `RESP_OKAY);
    wr(`OFF_ALT_SELECT_SECOND, 32'h000F0F00, `RESP_OKAY);
    wr(`OFF_AFEN, AF_EN, `RESP_OKAY);
    rd(`OFF_ALT_SELECT_FIRST, AF_SEL, `RESP_OKAY);
    settle();
    eoe = ((AF_SEL & 32'hAAAAAAAA) | (~AF_SEL & 32'h55555555)) & AF_EN | (~AF_EN & OUT_MASK);
    eout = ((AF_SEL & 32'hCCCCCCCC) | (~AF_SEL & 32'h33333333)) & AF_EN | (~AF_EN & GPIO_PAT);
    check(pin_oe, eoe);
    check(pin_out & pin_oe, eout & eoe);
    wr(`OFF_AFEN, 32'h00000041, `RESP_OKAY);
    for (int m = 1; m < 3; m++) begin
      @(posedge sys_clk);
      timer_out_mode <= 2'(m);
      timer_comp_out <= 2'b11;
      settle();
      check(32'({pin_oe[`PIN_A6], pin_oe[`PIN_A0]}), 32'(m));
      check(32'({pin_out[`PIN_A6] & pin_oe[`PIN_A6], pin_out[`PIN_A0] & pin_oe[`PIN_A0]}), 32'(m));
    end
    @(posedge sys_clk);
    xtal_enable <= 1'b1;
    settle();
    check(32'(pin_oe[1:0]), 32'h0);
    rd(`OFF_STATUS, 32'h2, `RESP_OKAY);
    @(posedge sys_clk);
    xtal_enable <= 1'b0;
  endtask

  task automatic t_led();
    logic [7:0]  hi, lo;
    logic [15:0] lv;
    hi = 8'h0F;
    lo = 8'h33;
    for (int k = 0; k < 8; k++) begin
      lv[2*k +: 2] = {hi[k], lo[k]};
    end
    wr(`OFF_LED_SINK_ENABLE, 32'h123456A5, `RESP_OKAY);
    wr(`OFF_LEDHI, 32'(hi), `RESP_OKAY);
    wr(`OFF_LEDLO, 32'(lo), `RESP_OKAY);
    settle();
    check(32'(led_sink_en), 32'hA5);
    check(32'(led_level), 32'(lv));
  endtask

  task automatic t_pd0();
    wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h4, `RESP_OKAY);
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      gpio_out[`PIN_D0] <= v[0];
      settle();
      check(32'({pin_oe[`PIN_D0], pin_out[`PIN_D0] & pin_oe[`PIN_D0]}), v ? 32'h0 : 32'h2);
      check(32'(pin_in_sync[`PIN_D0]), 32'h0);
      check(32'(ext_reset_req), 32'h0);
    end
    @(posedge sys_clk);
    reset_seq <= 1'b1;
    dbg_want <= 1'b1;
    gpio_out[`PIN_D0] <= 1'b0;
    @(posedge sys_clk);
    reset_seq <= 1'b0;
    dbg_want <= 1'b0;
    settle();
    check(32'(pin_oe[`PIN_D0]), 32'h0);
    rd(`OFF_STATUS, 32'h0, `RESP_OKAY);
  endtask

  task automatic t_bus();
    rd(8'h30, 32'h0, `RESP_SLVERR);
    wr(`OFF_IMPL, 32'h0, `RESP_SLVERR);
    rd(`OFF_IMPL, IMPL_MASK, `RESP_OKAY);
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    sys_clk = 1'b0;
    rstn = 1'b0;
    axil_req = '0;
    {gpio_out, func0_out, func0_oe, func1_out, func1_oe, ext_low} = '0;
    {timer_out_mode, timer_comp_out} = '0;
    {xtal_enable, reset_seq, chip_reset_drive, dbg_out, dbg_oe, dbg_want} = '0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_gpio();
    t_alt();
    t_led();
    t_pd0();
    t_bus();
    finish_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end
endmodule // pin_override_ctrl_bench
